// [verilog/axis_status_flag_logic.sv]
// Per-axis status flags and mirrored command relays of the motion controller
//
// What this block does
// (R1) Primary relay edges drive its legacy mirror high on rise, low on fall.
// (R2) Direct legacy writes leave the primary relay untouched; states may differ.
// (R3) Relay request beats a same-cycle data register request.
// (R4) Program itself clears the error history clear request; device never does.
// (R5) Three relays, clock set, clock read, error reset, sampled per main cycle.
// (R6) Flag bit address is base plus twenty times axis index.
// (R7) Small variant serves axis indices zero to seven only.
// (R8) Start-complete sets on servo-program start, not jog or pulse generator.
// (R9) Start-complete clears on complete-off rise or positioning completion.
// (R10) Positioning-complete sets on normal servo-program completion only.
// (R11) Positioning-complete clears on complete-off rise or positioning start.
// (R12) In-position sets when droop below range; clears at any start.
// (R13) In-position evaluated only inside the listed check windows.
// (R14) Command-in-position sets when position error below range; clears on starts.
// (R15) Command-in-position evaluated in position control, skipped in speed control.
// (R16) Speed-controlling flag follows speed control; low at power-on and position.
// (R17) Switch latch sets on speed to position; clears on listed starts.
// (R18) Zero-pass sets on zero passage and holds until reset or a zero-clearing home return start.
// (R19) Some home return methods clear zero-pass at start, reset next passage.
// (R20) Error flag sets on minor or major error; code stored by class.
// (R21) Error flag clears on per-axis error reset command.
// (R22) All flags clear on reset and update once per operation cycle.
module axis_status_flag_logic #(
	parameter int AXES = axis_flag_pkg::AXES_MAX
) (
	input  wire logic                                 clock,
	input  wire logic                                 rst_n,
	input  wire logic                                 op_tick,
	input  wire logic                                 main_tick,
	input  wire axis_flag_pkg::axis_event_t [AXES-1:0] axis_event,
	input  wire axis_flag_pkg::axis_cmd_t [AXES-1:0]   axis_cmd,
	input  wire logic [AXES-1:0][axis_flag_pkg::POS_W-1:0]  droop,
	input  wire logic [AXES-1:0][axis_flag_pkg::POS_W-1:0]  cmd_pos,
	input  wire logic [AXES-1:0][axis_flag_pkg::POS_W-1:0]  feed_pos,
	input  wire logic [axis_flag_pkg::POS_W-1:0]             in_pos_range,
	input  wire logic [axis_flag_pkg::POS_W-1:0]             cmd_in_pos_range,
	input  wire logic [AXES-1:0][axis_flag_pkg::CODE_W-1:0] err_code,
	input  wire axis_flag_pkg::relay_t                  relay_cmd,
	input  wire axis_flag_pkg::relay_t                  legacy_wr_en,
	input  wire axis_flag_pkg::relay_t                  legacy_wr_val,
	input  wire axis_flag_pkg::relay_t                  reg_req,
	output logic [AXES*axis_flag_pkg::FLAG_STRIDE-1:0]  flag_map,
	output axis_flag_pkg::relay_t                       legacy_relay,
	output axis_flag_pkg::relay_t                       relay_req,
	output axis_flag_pkg::relay_t                       req_from_relay,
	output logic [AXES-1:0][axis_flag_pkg::CODE_W-1:0]  minor_code,
	output logic [AXES-1:0][axis_flag_pkg::CODE_W-1:0]  major_code
);

	// Only the two device sizes are served; anything else is refused at elaboration
	// (R7) variant axis count
	if (AXES != axis_flag_pkg::AXES_MAX && AXES != axis_flag_pkg::AXES_SMALL) begin : g_bad_axes
		$error("AXES must be 8 or 32");
	end

	// Short alias of the flag reset pattern, keeps reset lines readable
	localparam logic [axis_flag_pkg::FLAG_COUNT-1:0] FRST = axis_flag_pkg::FLAGS_RESET;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Absolute difference of two signed positions
	function automatic logic [axis_flag_pkg::POS_W-1:0] abs_diff(
		input logic [axis_flag_pkg::POS_W-1:0] a,
		input logic [axis_flag_pkg::POS_W-1:0] b
	);
		logic signed [axis_flag_pkg::POS_W:0] d;
		d = $signed({a[axis_flag_pkg::POS_W-1], a}) - $signed({b[axis_flag_pkg::POS_W-1], b});
		if (d < 0)
			d = -d;
		return d[axis_flag_pkg::POS_W-1:0];
	endfunction

	// Bit address of one flag of one axis
	function automatic int flag_addr(input int axis_idx, input int ofs);
		return ofs + axis_flag_pkg::FLAG_STRIDE * axis_idx;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Per-axis flag state

	logic [AXES-1:0]                                 done_off_q;
	logic [AXES-1:0]                                 off_rise;
	logic [AXES-1:0]                                 start_done_q;
	logic [AXES-1:0]                                 pos_done_q;
	logic [AXES-1:0]                                 in_pos_q;
	logic [AXES-1:0]                                 cmd_in_pos_q;
	logic [AXES-1:0]                                 speed_ctl_q;
	logic [AXES-1:0]                                 sv_latch_q;
	logic [AXES-1:0]                                 zero_pass_q;
	logic [AXES-1:0]                                 err_det_q;
	logic [AXES-1:0][axis_flag_pkg::FLAG_COUNT-1:0] flags;

	// Edge memory for the complete-off command, per operation cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_off_q <= '0;
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				done_off_q[i] <= axis_cmd[i].done_off;
			end
		end
	end

	// Complete-off rise, judged against the level of the last operation cycle
	always_comb begin
		for (int i = 0; i < AXES; i++) begin
			off_rise[i] = axis_cmd[i].done_off && !done_off_q[i];
		end
	end

	// (R8) (R9) start-complete flag; a same-cycle start wins over the clears
	// (R22) cleared at reset, moves on operation cycles only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			start_done_q <= {AXES{FRST[axis_flag_pkg::OFS_START_DONE]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].servo_start)
					start_done_q[i] <= 1'b1;
				else if (off_rise[i] || axis_event[i].pos_done)
					start_done_q[i] <= 1'b0;
			end
		end
	end

	// (R10) (R11) positioning-complete flag; jog and home never report here
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pos_done_q <= {AXES{FRST[axis_flag_pkg::OFS_POS_DONE]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].pos_done)
					pos_done_q[i] <= 1'b1;
				else if (off_rise[i] || axis_event[i].servo_start)
					pos_done_q[i] <= 1'b0;
			end
		end
	end

	// (R12) (R13) in-position; a start restarts the check, so clear wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_pos_q <= {AXES{FRST[axis_flag_pkg::OFS_IN_POS]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].any_start)
					in_pos_q[i] <= 1'b0;
				else if (axis_event[i].in_pos_window && droop[i] < in_pos_range)
					in_pos_q[i] <= 1'b1;
			end
		end
	end

	// (R14) (R15) command-in-position; skipped while under speed control
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmd_in_pos_q <= {AXES{FRST[axis_flag_pkg::OFS_CMD_IN_POS]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].servo_start || axis_event[i].home_start
						|| axis_event[i].speed_start || axis_event[i].sv_start
						|| axis_event[i].jog_start || axis_event[i].mpg_start)
					cmd_in_pos_q[i] <= 1'b0;
				else if (!axis_event[i].speed_mode
						&& abs_diff(cmd_pos[i], feed_pos[i]) < cmd_in_pos_range)
					cmd_in_pos_q[i] <= 1'b1;
			end
		end
	end

	// (R16) speed-controlling follows the speed level, low at servo power-on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			speed_ctl_q <= {AXES{FRST[axis_flag_pkg::OFS_SPEED_CTL]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				speed_ctl_q[i] <= axis_event[i].speed_mode && !axis_event[i].servo_on_edge;
			end
		end
	end

	// (R17) switch latch; a switch in the start cycle still latches
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sv_latch_q <= {AXES{FRST[axis_flag_pkg::OFS_SV_LATCH]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].to_position)
					sv_latch_q[i] <= 1'b1;
				else if (axis_event[i].servo_start || axis_event[i].sv_start
						|| axis_event[i].speed_start || axis_event[i].jog_start
						|| axis_event[i].mpg_start)
					sv_latch_q[i] <= 1'b0;
			end
		end
	end

	// (R18) (R19) zero pass; only some home methods drop it at their start
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			zero_pass_q <= {AXES{FRST[axis_flag_pkg::OFS_ZERO_PASS]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].zero_cross)
					zero_pass_q[i] <= 1'b1;
				else if (axis_event[i].home_start && axis_event[i].home_zclear)
					zero_pass_q[i] <= 1'b0;
			end
		end
	end

	// (R20) (R21) error detection; a new error beats a held reset command
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			err_det_q <= {AXES{FRST[axis_flag_pkg::OFS_ERR_DET]}};
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_event[i].minor_err || axis_event[i].major_err)
					err_det_q[i] <= 1'b1;
				else if (axis_cmd[i].err_reset)
					err_det_q[i] <= 1'b0;
			end
		end
	end

	// Flags gathered per axis in their bit order
	always_comb begin
		for (int i = 0; i < AXES; i++) begin
			flags[i]                                = '0;
			flags[i][axis_flag_pkg::OFS_START_DONE] = start_done_q[i];
			flags[i][axis_flag_pkg::OFS_POS_DONE]   = pos_done_q[i];
			flags[i][axis_flag_pkg::OFS_IN_POS]     = in_pos_q[i];
			flags[i][axis_flag_pkg::OFS_CMD_IN_POS] = cmd_in_pos_q[i];
			flags[i][axis_flag_pkg::OFS_SPEED_CTL]  = speed_ctl_q[i];
			flags[i][axis_flag_pkg::OFS_SV_LATCH]   = sv_latch_q[i];
			flags[i][axis_flag_pkg::OFS_ZERO_PASS]  = zero_pass_q[i];
			flags[i][axis_flag_pkg::OFS_ERR_DET]    = err_det_q[i];
		end
	end

	// Error code storage by class
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < AXES; i++) begin
				minor_code[i] <= axis_flag_pkg::CODE_RESET;
				major_code[i] <= axis_flag_pkg::CODE_RESET;
			end
		end else if (op_tick) begin
			for (int i = 0; i < AXES; i++) begin
				// (R20) code by class
				if (axis_event[i].minor_err)
					minor_code[i] <= err_code[i];
				if (axis_event[i].major_err)
					major_code[i] <= err_code[i];
			end
		end
	end

	// Flags laid into the device bit map; gap bits stay zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_map <= '0;
		end else begin
			flag_map <= '0;
			for (int i = 0; i < AXES; i++) begin
				for (int k = 0; k < axis_flag_pkg::FLAG_COUNT; k++) begin
					// (R6) base plus stride
					flag_map[flag_addr(i, k)] <= flags[i][k];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Common command relays

	axis_flag_pkg::relay_t relay_prev_q;

	// Sample primary relays once per main cycle
	always_ff @(posedge clock) begin
		// (R5) main-cycle sampling
		if (!rst_n)
			relay_prev_q <= '0;
		else if (main_tick)
			relay_prev_q <= relay_cmd;
	end

	// Legacy mirror: edges of the primary relay, direct writes otherwise
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			legacy_relay <= '0;
		end else begin
			// (R2) direct write only touches mirror
			legacy_relay <= (legacy_relay & ~legacy_wr_en) | (legacy_wr_val & legacy_wr_en);
			if (main_tick) begin
				// (R1) rise sets, fall clears
				legacy_relay <= ((legacy_relay & ~legacy_wr_en)
					| (legacy_wr_val & legacy_wr_en)
					| (relay_cmd & ~relay_prev_q))
					& ~(~relay_cmd & relay_prev_q);
			end
		end
	end

	// Request arbitration; relay wins over data register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			relay_req      <= '0;
			req_from_relay <= '0;
		end else begin
			relay_req      <= '0;
			req_from_relay <= '0;
			if (main_tick) begin
				// (R3) relay has priority
				relay_req      <= (relay_cmd & ~relay_prev_q) | reg_req;
				req_from_relay <= relay_cmd & ~relay_prev_q;
			end
		end
	end

endmodule // axis_status_flag_logic

// [verilog/axis_flag_pkg.sv]
// Shared constants and carrier types for the axis status flag logic
package axis_flag_pkg;
	// Axis layout
	localparam int AXES_MAX     = 32;
	localparam int AXES_SMALL   = 8;
	localparam int FLAG_STRIDE  = 20;
	// Flag bit offsets within one axis block
	localparam int OFS_START_DONE = 0;
	localparam int OFS_POS_DONE   = 1;
	localparam int OFS_IN_POS     = 2;
	localparam int OFS_CMD_IN_POS = 3;
	localparam int OFS_SPEED_CTL  = 4;
	localparam int OFS_SV_LATCH   = 5;
	localparam int OFS_ZERO_PASS  = 6;
	localparam int OFS_ERR_DET    = 7;
	localparam int FLAG_COUNT     = 8;
	// Reset value of every flag byte
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// Widths
	localparam int POS_W  = 32;
	localparam int CODE_W = 16;
	localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

	// Per-axis events from the motion core, one-cycle pulses unless noted
	typedef struct packed {
		logic servo_start;      // Servo-program positioning start completed
		logic pos_done;         // Servo-program positioning completed normally
		logic any_start;        // Any start of the axis
		logic home_start;       // Home return start
		logic home_zclear;      // Home method clears zero pass at start
		logic speed_start;      // Speed control start
		logic sv_start;         // Speed/position switching start
		logic jog_start;        // Jog start
		logic mpg_start;        // Manual pulse operation start
		logic to_position;      // Speed to position switch happened
		logic speed_mode;       // Level: axis under speed control
		logic in_pos_window;    // Level: in-position check window open
		logic servo_on_edge;    // Servo amplifier power-on
		logic zero_cross;       // Zero point passed
		logic minor_err;        // Minor error detected
		logic major_err;        // Major error detected
	} axis_event_t;

	// Per-axis commands from the program, levels
	typedef struct packed {
		logic done_off;         // Complete-signal-off command
		logic err_reset;        // Error reset command
	} axis_cmd_t;

	// Common command relays and their legacy mirrors
	typedef struct packed {
		logic clk_set;
		logic clk_read;
		logic err_rst;
	} relay_t;
endpackage

// [testbench/axis_flag_properties.sv]
// Timing checker for the axis flag block, bound to its ports
module axis_flag_properties #(
	parameter int AXES = 8
) (
	input wire logic                                       clock,
	input wire logic                                       rst_n,
	input wire logic                                       op_tick,
	input wire logic                                       main_tick,
	input wire axis_flag_pkg::axis_event_t [AXES-1:0]      axis_event,
	input wire axis_flag_pkg::axis_cmd_t [AXES-1:0]        axis_cmd,
	input wire axis_flag_pkg::relay_t                      relay_cmd,
	input wire axis_flag_pkg::relay_t                      legacy_wr_en,
	input wire logic [AXES*axis_flag_pkg::FLAG_STRIDE-1:0] flag_map,
	input wire axis_flag_pkg::relay_t                      legacy_relay,
	input wire axis_flag_pkg::relay_t                      relay_req,
	input wire axis_flag_pkg::relay_t                      req_from_relay
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [2:0] last_q;
	wire  [2:0] rise = relay_cmd & ~last_q;
	wire  [2:0] fall = ~relay_cmd & last_q;
	////////////////////////////////////////////////////////////////
	// Relay level as last seen on a main cycle, edges judged from it
	always_ff @(posedge clock) begin
		if (!rst_n) last_q <= 3'h0;
		else if (main_tick) last_q <= relay_cmd;
	end
	a_mirror_rise: assert property (main_tick |=> (($past(rise) & ~legacy_relay) == 3'h0))
		else $error("legacy mirror missed a rise");
	a_mirror_fall: assert property (main_tick |=> (($past(fall) & legacy_relay) == 3'h0))
		else $error("legacy mirror missed a fall");
	a_relay_wins: assert property (main_tick |=> req_from_relay == $past(rise))
		else $error("relay source mark wrong");
	a_req_tick: assert property (!main_tick |=> relay_req == 3'h0)
		else $error("request outside main cycle");
	a_legacy_hold: assert property (!main_tick && legacy_wr_en == 3'h0 |=> $stable(legacy_relay))
		else $error("legacy mirror moved without cause");
	a_flag_quiet: assert property (!op_tick |-> ##2 $stable(flag_map))
		else $error("flags moved outside operation cycle");
	a_start_set: assert property (op_tick && axis_event[0].servo_start |-> ##2 flag_map[0])
		else $error("start complete not set");
	a_err_set: assert property (op_tick && (axis_event[0].minor_err || axis_event[0].major_err)
		|-> ##2 flag_map[7])
		else $error("error flag not set");
	a_err_clear: assert property (op_tick && axis_cmd[0].err_reset && !axis_event[0].minor_err
		&& !axis_event[0].major_err |-> ##2 !flag_map[7])
		else $error("error flag not cleared");
	a_spare_zero: assert property (flag_map[19:8] == 12'h000)
		else $error("spare flag bits not zero");
endmodule // axis_flag_properties
bind axis_status_flag_logic axis_flag_properties #(.AXES(AXES)) props (.clock, .rst_n, .op_tick,
	.main_tick, .axis_event, .axis_cmd, .relay_cmd, .legacy_wr_en, .flag_map, .legacy_relay,
	.relay_req, .req_from_relay);

// [testbench/plc_model.sv]
// Program-side model raising relay, data register and direct mirror requests
module plc_model (
	input wire logic               clock,
	output logic                   main_tick,
	output axis_flag_pkg::relay_t  relay_cmd,
	output axis_flag_pkg::relay_t  reg_req,
	output axis_flag_pkg::relay_t  legacy_wr_en,
	output axis_flag_pkg::relay_t  legacy_wr_val
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{main_tick, relay_cmd, reg_req, legacy_wr_en, legacy_wr_val} = 13'h0000;
	end
	////////////////////////////////////////////////////////////////
	// one main cycle
	// Relays are levels; only the strobes drop, so slow gaps are harmless
	task automatic req(input logic [2:0] cmd, rq, en, val, input int slow);
		repeat (slow) @(posedge clock);
		@(posedge clock);
		relay_cmd <= cmd;
		reg_req <= rq;
		legacy_wr_en <= en;
		legacy_wr_val <= val;
		main_tick <= 1'h1;
		@(posedge clock);
		main_tick <= 1'h0;
		reg_req <= 3'h0;
		legacy_wr_en <= 3'h0;
	endtask
endmodule // plc_model

// [testbench/testbench.sv]
// Self-checking bench for the axis status flag block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                                  clock, rst_n, op_tick, main_tick;
	axis_flag_pkg::axis_event_t [7:0]      axis_event;
	axis_flag_pkg::axis_cmd_t [7:0]        axis_cmd;
	logic [7:0][31:0]                      droop, cmd_pos, feed_pos;
	logic [31:0]                           in_pos_range, cmd_in_pos_range;
	logic [7:0][15:0]                      err_code, minor_code, major_code;
	axis_flag_pkg::relay_t                 relay_cmd, legacy_wr_en, legacy_wr_val, reg_req;
	axis_flag_pkg::relay_t                 legacy_relay, relay_req, req_from_relay;
	logic [159:0]                          flag_map;
	int                                    n_errors, num_checks, cycles;
	axis_status_flag_logic #(.AXES(8)) uut (.clock, .rst_n, .op_tick, .main_tick, .axis_event,
		.axis_cmd, .droop, .cmd_pos, .feed_pos, .in_pos_range, .cmd_in_pos_range, .err_code,
		.relay_cmd, .legacy_wr_en, .legacy_wr_val, .reg_req, .flag_map, .legacy_relay,
		.relay_req, .req_from_relay, .minor_code, .major_code);
	plc_model plc (.clock, .main_tick, .relay_cmd, .reg_req, .legacy_wr_en, .legacy_wr_val);
	////////////////////////////////////////////////////////////////
	// Compare, operation cycle and verdict helpers
	task automatic chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Flags show on the map two edges after the tick
	task automatic op(input int ax, input logic [15:0] ev, input logic [1:0] c);
		@(posedge clock);
		axis_event[ax] <= ev;
		axis_cmd[ax] <= c;
		op_tick <= 1'h1;
		@(posedge clock);
		op_tick <= 1'h0;
		axis_event[ax] <= 16'h0000;
		@(posedge clock);
		#1;
	endtask
	task automatic conclude();
		if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios: start complete, errors, in-position, speed, relays
	task automatic t_start();
		op(1, 16'h8000, 2'h0);
		chk(flag_map[20], 16'h0001);
		op(0, 16'h0100, 2'h0);
		chk(flag_map[0], 16'h0000);
		op(0, 16'h8000, 2'h0);
		chk(flag_map[0], 16'h0001);
		op(0, 16'h4000, 2'h0);
		chk(flag_map[1], 16'h0001);
		chk(flag_map[0], 16'h0000);
		op(0, 16'h8000, 2'h0);
		chk(flag_map[1], 16'h0000);
		op(1, 16'h0000, 2'h2);
		chk(flag_map[20], 16'h0000);
		op(1, 16'h0000, 2'h0);
	endtask
	task automatic t_error();
		err_code[0] <= 16'h0123;
		op(0, 16'h0002, 2'h0);
		chk(flag_map[7], 16'h0001);
		chk(minor_code[0], 16'h0123);
		err_code[0] <= 16'h0456;
		op(0, 16'h0001, 2'h0);
		chk(major_code[0], 16'h0456);
		op(0, 16'h0000, 2'h1);
		chk(flag_map[7], 16'h0000);
		op(0, 16'h0000, 2'h0);
	endtask
	task automatic t_position();
		droop[0] <= 32'h00000005;
		in_pos_range <= 32'h0000000A;
		op(0, 16'h0010, 2'h0);
		chk(flag_map[2], 16'h0001);
		op(0, 16'h2000, 2'h0);
		chk(flag_map[2], 16'h0000);
		op(0, 16'h0000, 2'h0);
		chk(flag_map[2], 16'h0000);
		cmd_pos[0] <= 32'h00000064;
		feed_pos[0] <= 32'h00000067;
		cmd_in_pos_range <= 32'h00000004;
		op(0, 16'h0000, 2'h0);
		chk(flag_map[3], 16'h0001);
		op(0, 16'h0020, 2'h0);
		chk(flag_map[4], 16'h0001);
		op(0, 16'h0000, 2'h0);
		chk(flag_map[4], 16'h0000);
		op(0, 16'h0040, 2'h0);
		chk(flag_map[5], 16'h0001);
		op(0, 16'h0200, 2'h0);
		chk(flag_map[5], 16'h0000);
		op(0, 16'h0004, 2'h0);
		chk(flag_map[6], 16'h0001);
		op(0, 16'h1800, 2'h0);
		chk(flag_map[6], 16'h0000);
	endtask
	task automatic t_relay();
		plc.req(3'h1, 3'h0, 3'h0, 3'h0, 0);
		#1;
		chk(legacy_relay, 16'h0001);
		chk(relay_req, 16'h0001);
		plc.req(3'h0, 3'h0, 3'h0, 3'h0, 1);
		#1;
		chk(legacy_relay, 16'h0000);
		plc.req(3'h0, 3'h0, 3'h2, 3'h2, 2);
		#1;
		chk(legacy_relay, 16'h0002);
		chk(relay_req, 16'h0000);
		plc.req(3'h4, 3'h4, 3'h0, 3'h0, 0);
		#1;
		chk(req_from_relay, 16'h0004);
		plc.req(3'h4, 3'h1, 3'h0, 3'h0, 0);
		#1;
		chk(relay_req, 16'h0001);
		chk(req_from_relay, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	// Clock, hang guard and main sequence
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		{rst_n, op_tick, axis_event, axis_cmd, droop, cmd_pos, feed_pos} = '0;
		{in_pos_range, cmd_in_pos_range, err_code} = '0;
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		t_start();
		t_error();
		t_position();
		t_relay();
		conclude();
	end
endmodule // testbench
